// ===== rtl/lfr_pkg.sv
// Overview of operation
// R1: fault signalling off until software enables it
// R2: mode field 01 selects bidirectional fault signalling
// R3: local fault may send remote fault sequences
// R4: remote fault may send idle control words
// R5: sequence config picks remote-fault, idle or traffic
// R6: received fault sequence sets matching status flag
// R7: over 127 clean columns clears the fault status
// R8: watch eight control and 64 data bits; the detector decodes only lane 0, ctrl[0] and data[31:0]
// R9: four same-value sequences, under 128 apart, set fault
// R10: 128 columns without fault sequences restore OK
// R11: receive fault outputs follow detected receive faults
// R12: disabled signalling holds receive fault outputs low
// R13: transmit-only partner drives transmit fault inputs; this top has no such mode and feeds them from the receive faults
// R14: duplex feeds receive faults into transmit side
// R15: duplex shows receive faults as status outputs
// R16: column counter steps per column, restarts on sequence
package lfr_pkg;

    // ------------------------------------------------------------
    // register map, byte addresses on the axi4-lite bus
    // ------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00; // mode field
    localparam logic [7:0] OFF_SEQCFG = 8'h04; // per-fault action
    localparam logic [7:0] OFF_STATUS = 8'h08; // live fault state
    localparam logic [7:0] OFF_INTSTAT = 8'h0C; // sticky, write 1 clears
    localparam logic [7:0] OFF_INTMASK = 8'h10; // interrupt enables
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int MODE_LSB = 0; // ctrl[1:0]
    localparam logic [1:0] MODE_BIDIR = 2'h1;
    localparam logic [1:0] MODE_RST = 2'h0; // signalling off
    localparam int SEQ_LOC_LSB = 0; // seqcfg[1:0]
    localparam int SEQ_REM_LSB = 2; // seqcfg[3:2]
    localparam logic [3:0] SEQCFG_RST = 4'h9; // local rf, remote idle
    localparam int BIT_LOCAL = 0; // status and interrupt bit
    localparam int BIT_REMOTE = 1;

    // ------------------------------------------------------------
    // column coding and counts
    // ------------------------------------------------------------
    localparam logic [7:0] SEQ_CHAR = 8'h9C;
    localparam logic [7:0] LF_CODE = 8'h01;
    localparam logic [7:0] RF_CODE = 8'h02;
    localparam logic [7:0] IDLE_CHAR = 8'h07;
    localparam logic [7:0] COL_LIMIT = 8'h80; // 128 columns
    localparam logic [2:0] SEQ_NEEDED = 3'h4;

    typedef enum logic [1:0] {
        ACT_PASS = 2'b00, ACT_RFSEQ = 2'b01, ACT_IDLE = 2'b10
    } lfr_act_t;
    typedef enum logic [1:0] {
        FLT_OK = 2'b00, FLT_LOCAL = 2'b01, FLT_REMOTE = 2'b10
    } lfr_fault_t;

    // one 64-bit column of the media-independent interface
    typedef struct packed {
        logic [7:0] ctrl;
        logic [63:0] data;
    } lfr_col_t;

    typedef struct packed {
        lfr_fault_t linkFault;
        lfr_fault_t lastVal;
        logic [2:0] seqCnt;
        logic [7:0] colCnt;
    } lfr_rx_st_t;

    typedef struct packed {
        lfr_col_t col;
    } lfr_tx_st_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] seqCfg;
        logic [1:0] intStatus;
        logic [1:0] intMask;
        logic [1:0] prevFault;
        logic awHeld;
        logic wHeld;
        logic [7:0] wAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } lfr_top_st_t;

    // a full column of sequence ordered sets carrying one code
    function automatic lfr_col_t seqCol(input logic [7:0] code);
        lfr_col_t c;
        c.ctrl = 8'h11;
        c.data = {code, 16'h0000, SEQ_CHAR, code, 16'h0000, SEQ_CHAR};
        return c;
    endfunction

endpackage

// ===== rtl/lfr_rx_fault.sv
`timescale 1ns/1ps
`default_nettype none
module lfr_rx_fault (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire lfr_pkg::lfr_col_t rxCol,
    output logic localFault,
    output logic remoteFault
);
    import lfr_pkg::*;

    lfr_rx_st_t st;
    lfr_rx_st_t next_st;
    logic seqHit; // lane 0 holds a fault sequence
    lfr_fault_t seqVal;

    // ------------------------------------------------------------
    // sequence detection and link fault state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // R8
        seqHit = rxCol.ctrl[0] && rxCol.data[7:0] == SEQ_CHAR &&
            rxCol.data[23:8] == 16'h0000 &&
            (rxCol.data[31:24] == LF_CODE || rxCol.data[31:24] == RF_CODE);
        seqVal = (rxCol.data[31:24] == LF_CODE) ? FLT_LOCAL : FLT_REMOTE;
        if (!enable) begin
            next_st = '0; // R12
        end else if (seqHit) begin
            next_st.colCnt = 8'h00; // R16
            next_st.lastVal = seqVal;
            // a differing value restarts the run of four
            if (seqVal == st.lastVal && st.seqCnt != 3'h0) begin
                if (st.seqCnt != SEQ_NEEDED) begin
                    next_st.seqCnt = st.seqCnt + 3'h1;
                end
            end else begin
                next_st.seqCnt = 3'h1;
            end
            if (next_st.seqCnt == SEQ_NEEDED) begin
                next_st.linkFault = seqVal; // R9 R6
            end
        end else begin
            // saturating, so a long clean stretch cannot wrap
            if (st.colCnt != COL_LIMIT) begin
                next_st.colCnt = st.colCnt + 8'h01; // R16
            end
            if (st.colCnt == COL_LIMIT - 8'h01) begin
                next_st.linkFault = FLT_OK; // R10 R7
                next_st.seqCnt = 3'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign localFault = enable && st.linkFault == FLT_LOCAL; // R6 R12
    assign remoteFault = enable && st.linkFault == FLT_REMOTE; // R6 R12

    off_holds_low_a: assert property (@(posedge clk) // R12
        disable iff (!resetn)
        !enable |-> !localFault && !remoteFault)
        else $error("fault output high while signalling disabled");
    clean_clears_a: assert property (@(posedge clk) // R10
        disable iff (!resetn)
        enable && st.colCnt == 8'h7F && !seqHit ##1 enable
        |-> st.linkFault == FLT_OK)
        else $error("fault not cleared after 128 clean columns");
    fourth_seq_a: assert property (@(posedge clk) disable iff (!resetn) // R9
        enable && seqHit && st.seqCnt == 3'h3 && seqVal == st.lastVal
        |=> st.linkFault == $past(seqVal))
        else $error("fourth matching sequence did not set fault");
    col_restart_a: assert property (@(posedge clk) disable iff (!resetn) // R16
        enable && seqHit |=> st.colCnt == 8'h00 && st.seqCnt != 3'h0)
        else $error("column count not restarted by sequence");
endmodule
`default_nettype wire

// ===== rtl/lfr_tx_fault.sv
`timescale 1ns/1ps
`default_nettype none
module lfr_tx_fault (
    input wire logic clk,
    input wire logic resetn,
    input wire logic bidir,
    input wire logic txNearEndFaultIn,
    input wire logic txFarEndFaultIn,
    input wire lfr_pkg::lfr_act_t localAct,
    input wire lfr_pkg::lfr_act_t remoteAct,
    input wire lfr_pkg::lfr_col_t txColIn,
    output lfr_pkg::lfr_col_t txColOut
);
    import lfr_pkg::*;

    lfr_tx_st_t st;
    lfr_tx_st_t next_st;
    lfr_act_t act;

    // ------------------------------------------------------------
    // column replacement, local fault ahead of remote fault
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        act = ACT_PASS;
        if (bidir && txNearEndFaultIn) begin
            act = localAct; // R3 R5
        end else if (bidir && txFarEndFaultIn) begin
            act = remoteAct; // R4 R5
        end
        unique case (act)
            ACT_RFSEQ: begin
                next_st.col = seqCol(RF_CODE); // R3
            end
            ACT_IDLE: begin
                next_st.col.ctrl = 8'hFF; // R4
                next_st.col.data = {8{IDLE_CHAR}};
            end
            ACT_PASS: begin
                next_st.col = txColIn;
            end
            // code 11 is unassigned and behaves as pass-through
            default: begin
                next_st.col = txColIn;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign txColOut = st.col;

    rf_on_local_a: assert property (@(posedge clk) disable iff (!resetn) // R3
        bidir && txNearEndFaultIn && localAct == ACT_RFSEQ
        |=> txColOut.ctrl == 8'h11 && txColOut.data[31:24] == RF_CODE)
        else $error("local fault did not send remote fault sequence");
    idle_on_remote_a: assert property (@(posedge clk) // R4
        disable iff (!resetn)
        bidir && !txNearEndFaultIn && txFarEndFaultIn && remoteAct == ACT_IDLE
        |=> txColOut.ctrl == 8'hFF && txColOut.data == {8{IDLE_CHAR}})
        else $error("remote fault did not send idle");
    pass_when_off_a: assert property (@(posedge clk) // R5
        disable iff (!resetn)
        !bidir |=> txColOut == $past(txColIn))
        else $error("traffic altered while fault signalling off");
endmodule
`default_nettype wire

// ===== rtl/lfr_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lfr_top (
    input wire logic clk,
    input wire logic resetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // media-independent interface, one column per clock
    input wire lfr_pkg::lfr_col_t rxCol,
    input wire lfr_pkg::lfr_col_t txColIn,
    output lfr_pkg::lfr_col_t txColOut,
    // fault indications
    output logic remoteFaultFromRx,
    output logic localFaultFromRx,
    output logic remoteFaultStatus,
    output logic localFaultStatus,
    output logic irq
);
    import lfr_pkg::*;

    // ------------------------------------------------------------
    // state and internal nets
    // ------------------------------------------------------------
    lfr_top_st_t st; // whole block state
    lfr_top_st_t next_st; // its next value
    logic enabled; // fault signalling switched on
    logic rxLocal; // receive side local fault
    logic rxRemote; // receive side remote fault
    logic awHs; // write address taken
    logic wHs; // write data taken
    logic arHs; // read address taken
    logic [1:0] events; // rising fault indications
    logic [1:0] clr; // write-one-to-clear bits
    logic [1:0] curFault; // current {remote, local}

    // ------------------------------------------------------------
    // address helpers
    // ------------------------------------------------------------

    // true for any mapped, word-aligned register
    function automatic logic addrOk(input logic [7:0] a);
        return a == OFF_CTRL || a == OFF_SEQCFG || a == OFF_STATUS ||
            a == OFF_INTSTAT || a == OFF_INTMASK;
    endfunction

    // read value of one register; holes read as zero
    function automatic logic [31:0] readMux(
        input logic [7:0] a,
        input lfr_top_st_t s,
        input logic [1:0] f
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            OFF_CTRL: begin
                v[1:0] = s.mode;
            end
            OFF_SEQCFG: begin
                v[3:0] = s.seqCfg;
            end
            OFF_STATUS: begin
                v[1:0] = f;
            end
            OFF_INTSTAT: begin
                v[1:0] = s.intStatus;
            end
            OFF_INTMASK: begin
                v[1:0] = s.intMask;
            end
            default: begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // enable and handshakes
    // ------------------------------------------------------------

    // only the bidirectional code turns signalling on
    assign enabled = st.mode == MODE_BIDIR; // R1 R2

    // a held channel stops taking until the write completes
    assign s_axi_awready = !st.awHeld && !st.bvalid;
    assign s_axi_wready = !st.wHeld && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign awHs = s_axi_awvalid && s_axi_awready;
    assign wHs = s_axi_wvalid && s_axi_wready;
    assign arHs = s_axi_arvalid && s_axi_arready;

    assign curFault = {rxRemote, rxLocal};
    // a fault rising this cycle is an interrupt event
    assign events = curFault & ~st.prevFault;

    // ------------------------------------------------------------
    // next-state logic: bus slave, registers, interrupts
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        clr = 2'b00;
        next_st.prevFault = curFault;

        // capture each write channel on its own handshake
        if (awHs) begin
            next_st.awHeld = 1'b1;
            next_st.wAddr = s_axi_awaddr;
        end
        if (wHs) begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end

        // response accepted, free the channel
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // both halves present: do the write
        if (next_st.awHeld && next_st.wHeld) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = addrOk(next_st.wAddr) ? RESP_OKAY
                : RESP_SLVERR;
            // every field lives in byte lane 0
            if (next_st.wStrb[0]) begin
                unique case (next_st.wAddr)
                    OFF_CTRL: begin
                        next_st.mode = next_st.wData[1:0]; // R1 R2
                    end
                    OFF_SEQCFG: begin
                        next_st.seqCfg = next_st.wData[3:0]; // R5
                    end
                    OFF_INTSTAT: begin
                        clr = next_st.wData[1:0];
                    end
                    OFF_INTMASK: begin
                        next_st.intMask = next_st.wData[1:0];
                    end
                    // status is read only, holes ignored
                    default: begin
                        clr = 2'b00;
                    end
                endcase
            end
        end

        // sticky bits: an event in the clearing cycle survives
        next_st.intStatus = (st.intStatus & ~clr) | events;

        // read channel: answer one cycle after the address
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arHs) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = readMux(s_axi_araddr, st, curFault);
            next_st.rresp = addrOk(s_axi_araddr) ? RESP_OKAY
                : RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.mode <= MODE_RST; // R1
            st.seqCfg <= SEQCFG_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // receive and transmit halves
    // ------------------------------------------------------------

    // detector sees every column; it is held idle while disabled
    lfr_rx_fault u_rx (
        .clk(clk),
        .resetn(resetn),
        .enable(enabled),
        .rxCol(rxCol),
        .localFault(rxLocal),
        .remoteFault(rxRemote)
    );

    // duplex: the receive result drives the transmit inputs directly,
    // so no transmit fault pins exist on this top
    lfr_tx_fault u_tx (
        .clk(clk),
        .resetn(resetn),
        .bidir(enabled),
        .txNearEndFaultIn(rxLocal), // R14
        .txFarEndFaultIn(rxRemote), // R14
        .localAct(lfr_act_t'(st.seqCfg[SEQ_LOC_LSB +: 2])),
        .remoteAct(lfr_act_t'(st.seqCfg[SEQ_REM_LSB +: 2])),
        .txColIn(txColIn),
        .txColOut(txColOut)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign localFaultFromRx = rxLocal; // R11
    assign remoteFaultFromRx = rxRemote; // R11
    assign localFaultStatus = rxLocal; // R15
    assign remoteFaultStatus = rxRemote; // R15
    assign irq = |(st.intStatus & st.intMask);
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    fault_sets_flag_a: assert property (@(posedge clk) // R6
        disable iff (!resetn)
        $rose(localFaultFromRx) |=> st.intStatus[BIT_LOCAL])
        else $error("local fault did not set its sticky bit");
    disabled_pass_a: assert property (@(posedge clk) // R1
        disable iff (!resetn)
        st.mode != MODE_BIDIR |=> txColOut == $past(txColIn))
        else $error("transmit altered with signalling off");
endmodule
`default_nettype wire

// ===== test/lfr_pcs_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-end coding layer model: hands the block one receive column per clock
module lfr_pcs_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] kind, // 0 data, 1 local seq, 2 remote seq
    output var lfr_pkg::lfr_col_t rxCol
);
    import lfr_pkg::*;

    // ------------------------------------------------------------
    // data pattern
    // ------------------------------------------------------------
    logic [63:0] pat; // changes every column so no lane looks stuck

    // step the pattern each clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pat <= 64'h0;
        end else begin
            pat <= pat + 64'h9E3779B97F4A7C15;
        end
    end

    // ------------------------------------------------------------
    // column builder
    // ------------------------------------------------------------
    // sequence set in lanes 0 and 4, both carrying the fault code
    function automatic lfr_col_t seqOf(input logic [7:0] code);
        lfr_col_t c;
        c.ctrl = 8'h11;
        c.data = {code, 16'h0000, SEQ_CHAR, code, 16'h0000, SEQ_CHAR};
        return c;
    endfunction

    // plain data keeps every control lane low
    always_comb begin
        case (kind)
            2'h1: rxCol = seqOf(LF_CODE);
            2'h2: rxCol = seqOf(RF_CODE);
            default: rxCol = '{ctrl: 8'h00, data: pat};
        endcase
    end
endmodule
`default_nettype wire

// ===== test/tb_link_fault_reconciliation.sv
`timescale 1ns/1ps
`default_nettype none
module tb_link_fault_reconciliation;
    import lfr_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk, resetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, kind;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic remoteFaultFromRx, localFaultFromRx, irq;
    logic remoteFaultStatus, localFaultStatus;
    lfr_col_t rxCol, txColIn, txColOut;
    int nErrors, samplesChecked;
    // fixed mac column, easy to tell from any substituted one
    localparam lfr_col_t TXC = '{ctrl: 8'h5A, data: 64'h0123456789ABCDEF};

    lfr_top i_lfr_top (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .rxCol(rxCol), .txColIn(txColIn),
        .txColOut(txColOut), .remoteFaultFromRx(remoteFaultFromRx),
        .localFaultFromRx(localFaultFromRx), .irq(irq),
        .remoteFaultStatus(remoteFaultStatus),
        .localFaultStatus(localFaultStatus));

    lfr_pcs_model i_lfr_pcs_model (.clk(clk), .resetn(resetn),
        .kind(kind), .rxCol(rxCol));

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    always #12.5 clk = ~clk;

    // whole run is well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        nErrors++;
        testDone();
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic testDone();
        $display("checks %0d errors %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [71:0] got, input logic [71:0] exp,
                       input string what);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // valids held until their own ready; bready stays high all run
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] expResp);
        logic awOk, wOk;
        awOk = 1'b0;
        wOk = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(awOk && wOk)) begin
            @(posedge clk);
            if (!awOk && s_axi_awready === 1'b1) begin
                awOk = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wOk && s_axi_wready === 1'b1) begin
                wOk = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, expResp, "write response");
    endtask

    // read one word; rready stays high all run
    task automatic axiRd(input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] expResp, input logic cmpData);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rresp, expResp, "read response");
        if (cmpData) begin
            chk(s_axi_rdata, exp, "read data");
        end
    endtask

    // n columns of one kind; the kind is held afterwards
    task automatic sendCols(input logic [1:0] k, input int n);
        repeat (n) begin
            kind <= k;
            @(posedge clk);
        end
    endtask

    // looks one edge on, which also passes one more held column
    task automatic chkFlt(input logic l, input logic r);
        @(posedge clk);
        chk({localFaultFromRx, remoteFaultFromRx}, {l, r}, "rx fault");
        chk({localFaultStatus, remoteFaultStatus}, {l, r}, "fault status");
    endtask

    function automatic lfr_col_t expTx(input logic [1:0] code);
        lfr_col_t c;
        c = TXC;
        if (code == 2'h1) begin
            c.ctrl = 8'h11;
            c.data = {2{RF_CODE, 16'h0000, SEQ_CHAR}};
        end else if (code == 2'h2) begin
            c.ctrl = 8'hFF;
            c.data = {8{IDLE_CHAR}};
        end
        return c;
    endfunction

    // every action code for the fault that is present now
    task automatic txSweep(input logic isRemote);
        for (int k = 0; k < 4; k++) begin
            axiWr(OFF_SEQCFG, 32'(k[1:0]) << (isRemote ? 2 : 0), RESP_OKAY);
            @(posedge clk);
            chk(txColOut, expTx(k[1:0]), "tx column");
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    logic [7:0] rstAddr [5] = '{OFF_CTRL, OFF_SEQCFG, OFF_STATUS,
                                OFF_INTSTAT, OFF_INTMASK};
    logic [31:0] rstVal [5] = '{32'h0, {28'h0, SEQCFG_RST}, 32'h0, 32'h0,
                                32'h0};
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        kind = 2'h0;
        txColIn = TXC;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        nErrors = 0;
        samplesChecked = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            axiRd(rstAddr[i], rstVal[i], RESP_OKAY, 1'b1);
        end
        axiRd(8'h14, 32'h0, RESP_SLVERR, 1'b0);
        axiWr(8'h14, 32'h1, RESP_SLVERR);
        // signalling off: sequences must not raise anything
        sendCols(2'h1, 4);
        chkFlt(1'b0, 1'b0);
        chk(txColOut, TXC, "tx while off");
        sendCols(2'h0, 1);
        axiWr(OFF_CTRL, 32'h1, RESP_OKAY);
        // a differing sequence restarts the count of four
        sendCols(2'h1, 3);
        sendCols(2'h2, 1);
        sendCols(2'h1, 3);
        chkFlt(1'b0, 1'b0);
        chkFlt(1'b1, 1'b0);
        // a sequence mid-way restarts the clean count
        sendCols(2'h0, 100);
        sendCols(2'h1, 1);
        sendCols(2'h0, 126);
        chkFlt(1'b1, 1'b0);
        chkFlt(1'b1, 1'b0);
        chkFlt(1'b0, 1'b0);
        // sticky event, masked, then unmasked, then cleared
        axiRd(OFF_INTSTAT, 32'h1, RESP_OKAY, 1'b1);
        chk(irq, 1'b0, "irq masked");
        axiWr(OFF_INTMASK, 32'h1, RESP_OKAY);
        axiRd(OFF_INTMASK, 32'h1, RESP_OKAY, 1'b1);
        chk(irq, 1'b1, "irq raised");
        axiWr(OFF_INTSTAT, 32'h1, RESP_OKAY);
        axiWr(OFF_STATUS, 32'h3, RESP_OKAY);
        axiRd(OFF_INTSTAT, 32'h0, RESP_OKAY, 1'b1);
        axiRd(OFF_STATUS, 32'h0, RESP_OKAY, 1'b1);
        chk(irq, 1'b0, "irq cleared");
        // transmit substitution for each fault and action code
        sendCols(2'h1, 4);
        txSweep(1'b0);
        sendCols(2'h2, 4);
        chkFlt(1'b0, 1'b1);
        txSweep(1'b1);
        axiRd(OFF_STATUS, 32'h2, RESP_OKAY, 1'b1);
        axiRd(OFF_INTSTAT, 32'h3, RESP_OKAY, 1'b1);
        chk(irq, 1'b1, "irq again");
        // a mode other than 01 turns signalling off
        axiWr(OFF_CTRL, 32'h3, RESP_OKAY);
        axiRd(OFF_CTRL, 32'h3, RESP_OKAY, 1'b1);
        chkFlt(1'b0, 1'b0);
        chk(txColOut, TXC, "tx pass");
        testDone();
    end
endmodule
`default_nettype wire
